// [gsf_host_model.sv]
// Host model that reads the status bank and writes its event mask
`timescale 1ns/10ps
module gsf_host_model
	import gsf_pkg::*;
(
	input  wire logic        mclk,     // Bank clock
	input  wire logic [15:0] rd_data,  // Read data from bank
	input  wire logic        rd_valid, // Read data valid pulse
	output logic             rd_en,    // Read strobe
	output logic      [7:0]  rd_addr,  // Read offset
	output logic             wr_en,    // Write strobe
	output logic      [7:0]  wr_addr,  // Write offset
	output logic      [15:0] wr_data   // Write data
);
	// ****************************************************************
	// Bus cycles
	// ****************************************************************
	initial
	begin
		rd_en = 1'b0;
		rd_addr = 8'hff;
		wr_en = 1'b0;
		wr_addr = 8'hff;
		wr_data = 16'hffff;
	end

	// Released lines show the inverse so stale values never look valid
	task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
		@(posedge mclk);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge mclk);
		rd_en <= 1'b0;
		rd_addr <= ~a;
		@(posedge mclk);
		ok = rd_valid;
		d = rd_data;
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge mclk);
		wr_en <= 1'b0;
		wr_addr <= ~a;
		wr_data <= ~d;
	endtask : wr
endmodule : gsf_host_model

// [gsf_pkg.sv]
// Package for the general status and analog limit flag register bank
package gsf_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0]  GSF_OFS_MASK  = 8'h1e;
	localparam logic [7:0]  GSF_OFS_GEN   = 8'h21;
	localparam logic [7:0]  GSF_OFS_LIMIT = 8'h23;
	localparam logic [7:0]  GSF_OFS_AIN0  = 8'h24;

	// ****************************************************************
	// Field positions in the general status, limit and result words
	// ****************************************************************
	localparam int          GSF_BIT_ALARM      = 15;
	localparam int          GSF_BIT_TRIM_BUSY  = 12;
	localparam int          GSF_BIT_ST_RUN     = 11;
	localparam int          GSF_BIT_ST_DONE    = 10;
	localparam int          GSF_BIT_ST_FAIL    = 9;
	localparam int          GSF_BIT_RESET_SEEN = 8;
	localparam int          GSF_BIT_SLEW_IDLE  = 7;
	localparam int          GSF_BIT_CONV_DONE  = 6;
	localparam int          GSF_BIT_CONV_ACT   = 5;
	localparam int          GSF_BIT_SUPPLY_HI  = 4;
	localparam int          GSF_BIT_BRK_FRAME  = 3;
	localparam int          GSF_BIT_BRK_PAR    = 2;
	localparam int          GSF_BIT_CHR_FRAME  = 1;
	localparam int          GSF_BIT_CHR_PAR    = 0;
	localparam int          GSF_LIMIT_LSB      = 1;
	localparam int          GSF_RESULT_W       = 12;

	// ****************************************************************
	// Reset values and masks
	// ****************************************************************
	localparam logic [15:0] GSF_RST_GEN       = 16'h1180;
	localparam logic [15:0] GSF_RST_MASK      = 16'hffff;
	localparam logic [15:0] GSF_MASK_WRITABLE = 16'h06cf;
	localparam logic [15:0] GSF_RST_LIMIT     = 16'h0000;
	localparam logic [15:0] GSF_RST_AIN0      = 16'h0000;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int          GSF_SLEW_IDLE_CYC = 3;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic selftest_done;
		logic selftest_fail;
		logic conv_done;
		logic break_frame_err;
		logic break_parity_err;
		logic char_frame_err;
		logic char_parity_err;
	} gsf_event_type;

	typedef struct packed {
		logic output_voltage_limit_fail;
		logic zero_tempco_limit_fail;
		logic core_supply_limit_fail;
		logic pin_supply_limit_fail;
		logic reference_limit_fail;
		logic temperature_limit_fail;
		logic aux_input1_limit_fail;
		logic aux_input0_limit_fail;
	} gsf_limit_type;

	typedef struct packed {
		logic                    alarm_irq;
		logic                    trim_busy;
		logic                    selftest_run;
		logic                    selftest_done;
		logic                    selftest_fail;
		logic                    reset_seen;
		logic                    slew_idle;
		logic                    conv_done;
		logic                    conv_active;
		logic                    supply_meta;
		logic                    supply_sync;
		logic [3:0]              serial_err;
		logic                    slew_event;
		logic [15:0]             mask;
		gsf_limit_type           limit;
		logic [GSF_RESULT_W-1:0] ain0;
		logic [15:0]             rd_data;
		logic                    rd_valid;
	} gsf_state_type;

	localparam gsf_state_type GSF_RST_STATE = '{
		alarm_irq:     GSF_RST_GEN[GSF_BIT_ALARM],
		trim_busy:     GSF_RST_GEN[GSF_BIT_TRIM_BUSY],
		selftest_run:  GSF_RST_GEN[GSF_BIT_ST_RUN],
		selftest_done: GSF_RST_GEN[GSF_BIT_ST_DONE],
		selftest_fail: GSF_RST_GEN[GSF_BIT_ST_FAIL],
		reset_seen:    GSF_RST_GEN[GSF_BIT_RESET_SEEN],
		slew_idle:     GSF_RST_GEN[GSF_BIT_SLEW_IDLE],
		conv_done:     GSF_RST_GEN[GSF_BIT_CONV_DONE],
		conv_active:   GSF_RST_GEN[GSF_BIT_CONV_ACT],
		supply_meta:   1'b0,
		supply_sync:   GSF_RST_GEN[GSF_BIT_SUPPLY_HI],
		serial_err:    GSF_RST_GEN[GSF_BIT_BRK_FRAME:GSF_BIT_CHR_PAR],
		slew_event:    1'b0,
		mask:          GSF_RST_MASK,
		limit:         GSF_RST_LIMIT[GSF_LIMIT_LSB+7:GSF_LIMIT_LSB],
		ain0:          GSF_RST_AIN0[GSF_RESULT_W-1:0],
		rd_data:       16'h0000,
		rd_valid:      1'b0
	};

endpackage : gsf_pkg

// [gsf_status_bank.sv]
// General status, analog limit flag and auxiliary result register bank
`timescale 1ns/10ps

// Overview of operation
// - Bit 15 ORs unmasked alarm status bits 14-0
// - Trim busy high from power-up until copy
// - Bit 11 shows self-test run enable
// - Self-test done sticky, clears on read
// - Self-test fail sticky, clears on read
// - Reset-occurred set by reset, read clears
// - Slew idle high when applied equals target
// - Slew idle rises within 3 cycles
// - Slew reach event when enabled, maskable
// - Conversion complete sticky, clears on read
// - Conversion active is live, no interrupt
// - Supply high is live comparator copy
// - Break framing error sticky, clear on read
// - Break parity error sticky, clear on read
// - Character framing error sticky, clear on read
// - Character parity error sticky, clear on read
// - Limit fail flags at bits 8 to 1
// - Aux input 0 result in bits 11-0
// - Mask blocks summary, status still sets
// - All mask bits reset to one
// - Summary flag ORs unmasked general status
module gsf_status_bank
	import gsf_pkg::*;
(
	input  wire logic                    mclk,                 // 100 MHz clock
	input  wire logic                    arst_n,               // Async reset, active low
	input  wire logic                    ce,                   // Clock enable
	input  wire logic                    rd_en,                // Register read strobe
	input  wire logic [7:0]              rd_addr,              // Register read offset
	output logic      [15:0]             rd_data,              // Read data
	output logic                         rd_valid,             // Read data valid pulse
	input  wire logic                    wr_en,                // Register write strobe
	input  wire logic [7:0]              wr_addr,              // Register write offset
	input  wire logic [15:0]             wr_data,              // Write data
	input  wire logic [15:0]             alarm_status_word,    // Alarm status word
	input  wire logic [15:0]             alarm_mask_word,      // Alarm mask word
	input  wire logic                    trim_copy_done,       // Trim copy finished
	input  wire logic                    selftest_run_enable,  // Self-test enabled
	input  wire gsf_event_type           events,               // Sticky event conditions
	input  wire logic                    adc_converting,       // ADC converting
	input  wire logic                    pin_supply_high,      // Async supply comparator
	input  wire logic [15:0]             applied_code,         // Applied output code
	input  wire logic [15:0]             target_code,          // Target output code
	input  wire logic                    slew_enable,          // Slew limiting on
	input  wire gsf_limit_type           limit_fail,           // Limit fail flags
	input  wire logic [GSF_RESULT_W-1:0] aux0_result,          // Aux input 0 result
	input  wire logic                    aux0_result_valid,    // Result strobe
	output logic                         general_summary_flag, // Unmasked status OR
	output logic                         slew_reach_event      // Slew target reached
);

	// ****************************************************************
	// State
	// ****************************************************************
	gsf_state_type state;
	gsf_state_type next_state;
	logic [15:0]   gen_word;
	logic [15:0]   mask_word;
	logic [15:0]   limit_word;
	logic [15:0]   ain0_word;
	logic          rd_hit_gen;
	logic          wr_hit_mask;
	logic          codes_equal;

	// Set beats clear so an event in the read cycle survives
	function automatic logic sticky_next(input logic cur, input logic ev, input logic clr);
		sticky_next = ev | (cur & ~clr);
	endfunction : sticky_next

	// ****************************************************************
	// Register views
	// ****************************************************************
	always_comb
	begin
		gen_word                     = '0;
		gen_word[GSF_BIT_ALARM]      = state.alarm_irq;
		gen_word[GSF_BIT_TRIM_BUSY]  = state.trim_busy;
		gen_word[GSF_BIT_ST_RUN]     = state.selftest_run;
		gen_word[GSF_BIT_ST_DONE]    = state.selftest_done;
		gen_word[GSF_BIT_ST_FAIL]    = state.selftest_fail;
		gen_word[GSF_BIT_RESET_SEEN] = state.reset_seen;
		gen_word[GSF_BIT_SLEW_IDLE]  = state.slew_idle;
		gen_word[GSF_BIT_CONV_DONE]  = state.conv_done;
		gen_word[GSF_BIT_CONV_ACT]   = state.conv_active;
		gen_word[GSF_BIT_SUPPLY_HI]  = state.supply_sync;
		gen_word[GSF_BIT_BRK_FRAME:GSF_BIT_CHR_PAR] = state.serial_err;
		limit_word                   = '0;
		limit_word[GSF_LIMIT_LSB+7:GSF_LIMIT_LSB] = state.limit;
		ain0_word                    = '0;
		ain0_word[GSF_RESULT_W-1:0]  = state.ain0;
	end

	// Reserved mask bits are fixed at one, which also keeps status-only bits out
	assign mask_word   = (state.mask & GSF_MASK_WRITABLE) | ~GSF_MASK_WRITABLE;
	assign rd_hit_gen  = rd_en && (rd_addr == GSF_OFS_GEN);
	assign wr_hit_mask = wr_en && (wr_addr == GSF_OFS_MASK);
	assign codes_equal = (applied_code == target_code);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		next_state               = state;
		// Bit 15 of the alarm word is our own summary, left out to avoid a loop
		next_state.alarm_irq     = |(alarm_status_word[14:0] & ~alarm_mask_word[14:0]);
		next_state.trim_busy     = state.trim_busy & ~trim_copy_done;
		next_state.selftest_run  = selftest_run_enable;
		next_state.selftest_done = sticky_next(state.selftest_done, events.selftest_done,
			rd_hit_gen);
		next_state.selftest_fail = sticky_next(state.selftest_fail, events.selftest_fail,
			rd_hit_gen);
		next_state.reset_seen    = state.reset_seen & ~rd_hit_gen;
		next_state.slew_idle     = codes_equal;
		next_state.slew_event    = slew_enable & codes_equal & ~state.slew_idle
			& ~mask_word[GSF_BIT_SLEW_IDLE];
		next_state.conv_done     = sticky_next(state.conv_done, events.conv_done,
			rd_hit_gen);
		next_state.conv_active   = adc_converting;
		next_state.supply_meta   = pin_supply_high;
		next_state.supply_sync   = state.supply_meta;
		next_state.serial_err[3] = sticky_next(state.serial_err[3], events.break_frame_err,
			rd_hit_gen);
		next_state.serial_err[2] = sticky_next(state.serial_err[2], events.break_parity_err,
			rd_hit_gen);
		next_state.serial_err[1] = sticky_next(state.serial_err[1], events.char_frame_err,
			rd_hit_gen);
		next_state.serial_err[0] = sticky_next(state.serial_err[0], events.char_parity_err,
			rd_hit_gen);
		next_state.limit         = limit_fail;
		if (aux0_result_valid)
		begin
			next_state.ain0 = aux0_result;
		end
		if (wr_hit_mask)
		begin
			next_state.mask = (wr_data & GSF_MASK_WRITABLE) | ~GSF_MASK_WRITABLE;
		end
		next_state.rd_valid      = rd_en;
		if (rd_en)
		begin
			// Captured from the current view, so sticky bits read before clearing
			unique case (rd_addr)
				GSF_OFS_MASK:  next_state.rd_data = mask_word;
				GSF_OFS_GEN:   next_state.rd_data = gen_word;
				GSF_OFS_LIMIT: next_state.rd_data = limit_word;
				GSF_OFS_AIN0:  next_state.rd_data = ain0_word;
				default:       next_state.rd_data = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= GSF_RST_STATE;
		end
		else if (ce)
		begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign rd_data              = state.rd_data;
	assign rd_valid             = state.rd_valid;
	assign general_summary_flag = |(gen_word & ~mask_word);
	assign slew_reach_event     = state.slew_event;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	property p_alarm_or;
		ce |=> gen_word[GSF_BIT_ALARM] ==
			$past(|(alarm_status_word[14:0] & ~alarm_mask_word[14:0]));
	endproperty
	a_alarm_or: assert property (p_alarm_or) else $error("alarm summary bit wrong");

	property p_trim_clear;
		ce && trim_copy_done |=> !gen_word[GSF_BIT_TRIM_BUSY] ##1 !gen_word[GSF_BIT_TRIM_BUSY];
	endproperty
	a_trim_clear: assert property (p_trim_clear) else $error("trim busy not cleared");

	property p_run_copy;
		ce |=> gen_word[GSF_BIT_ST_RUN] == $past(selftest_run_enable);
	endproperty
	a_run_copy: assert property (p_run_copy) else $error("run enable not shown");

	property p_done_sticky;
		ce && events.selftest_done |=> gen_word[GSF_BIT_ST_DONE];
	endproperty
	a_done_sticky: assert property (p_done_sticky) else $error("done bit not set");

	property p_fail_hold;
		gen_word[GSF_BIT_ST_FAIL] && !rd_hit_gen |=> gen_word[GSF_BIT_ST_FAIL];
	endproperty
	a_fail_hold: assert property (p_fail_hold) else $error("fail bit lost");

	property p_reset_clear;
		ce && rd_hit_gen |=> !gen_word[GSF_BIT_RESET_SEEN];
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset bit kept");

	property p_slew_fast;
		(ce && !slew_enable && applied_code == target_code)[*3] |-> gen_word[GSF_BIT_SLEW_IDLE];
	endproperty
	a_slew_fast: assert property (p_slew_fast) else $error("slew idle late");

	property p_set_wins;
		ce && rd_hit_gen && events.conv_done |=> gen_word[GSF_BIT_CONV_DONE];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost on read");

	property p_parity_clear;
		ce && rd_hit_gen && !events.char_parity_err |=> !gen_word[GSF_BIT_CHR_PAR];
	endproperty
	a_parity_clear: assert property (p_parity_clear) else $error("parity bit kept");

	property p_supply_live;
		(ce && pin_supply_high)[*3] |-> gen_word[GSF_BIT_SUPPLY_HI];
	endproperty
	a_supply_live: assert property (p_supply_live) else $error("supply bit stale");

	property p_masked_quiet;
		mask_word == GSF_RST_MASK |-> !general_summary_flag && !slew_reach_event;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet) else $error("masked summary high");

	property p_read_capture;
		ce && rd_hit_gen |=> rd_valid && rd_data == $past(gen_word);
	endproperty
	a_read_capture: assert property (p_read_capture) else $error("read value wrong");

	property p_ain0_load;
		ce && aux0_result_valid |=> state.ain0 == $past(aux0_result);
	endproperty
	a_ain0_load: assert property (p_ain0_load) else $error("result not loaded");

	property p_trim_hold;
		!gen_word[GSF_BIT_TRIM_BUSY] |=> !gen_word[GSF_BIT_TRIM_BUSY];
	endproperty
	a_trim_hold: assert property (p_trim_hold) else $error("trim busy came back");

	property p_active_live;
		ce && arst_n |=> gen_word[GSF_BIT_CONV_ACT] == $past(adc_converting);
	endproperty
	a_active_live: assert property (p_active_live) else $error("active bit stale");

	property p_brk_frame_set;
		ce && events.break_frame_err |=> gen_word[GSF_BIT_BRK_FRAME];
	endproperty
	a_brk_frame_set: assert property (p_brk_frame_set) else $error("break frame not set");

	property p_brk_par_set;
		ce && events.break_parity_err |=> gen_word[GSF_BIT_BRK_PAR];
	endproperty
	a_brk_par_set: assert property (p_brk_par_set) else $error("break parity not set");

	property p_chr_frame_set;
		ce && events.char_frame_err |=> gen_word[GSF_BIT_CHR_FRAME];
	endproperty
	a_chr_frame_set: assert property (p_chr_frame_set) else $error("char frame not set");

	// Reset edge left out: the limit copy is forced to zero there
	property p_limit_map;
		ce && arst_n |=> limit_word == {7'h00, $past(limit_fail), 1'b0};
	endproperty
	a_limit_map: assert property (p_limit_map) else $error("limit flags misplaced");

	property p_status_only;
		mask_word[15:11] == 5'h1f && mask_word[GSF_BIT_RESET_SEEN]
			&& mask_word[GSF_BIT_CONV_ACT] && mask_word[GSF_BIT_SUPPLY_HI];
	endproperty
	a_status_only: assert property (p_status_only) else $error("status bit unmasked");

	property p_summary_set;
		gen_word[GSF_BIT_CONV_DONE] && !mask_word[GSF_BIT_CONV_DONE] |-> general_summary_flag;
	endproperty
	a_summary_set: assert property (p_summary_set) else $error("summary flag missing");

	property p_slew_reached;
		slew_reach_event |-> gen_word[GSF_BIT_SLEW_IDLE];
	endproperty
	a_slew_reached: assert property (p_slew_reached) else $error("slew event early");

	property p_valid_pulse;
		ce && !rd_en |=> !rd_valid;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("read valid too long");

	c_read_gen: cover property (ce && rd_hit_gen ##1 rd_data[GSF_BIT_RESET_SEEN]);
	c_slew_evt: cover property (slew_reach_event);
	c_summary:  cover property (general_summary_flag);
	c_race:     cover property (ce && rd_hit_gen && events.conv_done);

endmodule : gsf_status_bank

// [gsf_status_bank_tb.sv]
// Self-checking testbench of the status register bank
`timescale 1ns/10ps
module gsf_status_bank_tb
	import gsf_pkg::*;
;
	// ****************************************************************
	// Stimulus signals
	// ****************************************************************
	logic                    mclk = 1'b0;
	logic                    arst_n = 1'b0;
	logic                    ce = 1'b1;
	logic                    rd_en, wr_en, rd_valid, summary, slew_evt;
	logic [7:0]              rd_addr, wr_addr;
	logic [15:0]             rd_data, wr_data;
	logic [15:0]             alarm_word = 16'h0000;
	logic [15:0]             alarm_mask = 16'hffff;
	logic                    trim_done = 1'b0;
	logic                    run_en = 1'b0;
	gsf_event_type           ev = '0;
	logic                    converting = 1'b0;
	logic                    supply_hi = 1'b0;
	logic [15:0]             applied = 16'h0000;
	logic [15:0]             target = 16'h0000;
	logic                    slew_en = 1'b0;
	gsf_limit_type           limit = '0;
	logic [GSF_RESULT_W-1:0] ain0 = '0;
	logic                    ain0_vld = 1'b0;
	int                      error_cnt = 0;
	int                      checks_done = 0;
	int                      cyc = 0;
	int                      n;
	int                      pos [7] = '{0, 1, 2, 3, 6, 9, 10};

	always #5 mclk = ~mclk;

	gsf_status_bank uut (.mclk(mclk), .arst_n(arst_n), .ce(ce), .rd_en(rd_en),
		.rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .alarm_status_word(alarm_word),
		.alarm_mask_word(alarm_mask), .trim_copy_done(trim_done),
		.selftest_run_enable(run_en), .events(ev), .adc_converting(converting),
		.pin_supply_high(supply_hi), .applied_code(applied), .target_code(target),
		.slew_enable(slew_en), .limit_fail(limit), .aux0_result(ain0),
		.aux0_result_valid(ain0_vld), .general_summary_flag(summary),
		.slew_reach_event(slew_evt));

	gsf_host_model host (.mclk(mclk), .rd_data(rd_data), .rd_valid(rd_valid),
		.rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data));

	// ****************************************************************
	// Checking and closing
	// ****************************************************************
	task automatic results();
		$display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Every read must also answer with its valid pulse
	task automatic rc(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic        ok;
		host.rd(a, d, ok);
		chk({15'h0000, ok}, 16'h0001);
		chk(d, exp);
	endtask : rc

	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			error_cnt++;
			results();
		end
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial
	begin
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		rc(GSF_OFS_GEN, 16'h1180);
		rc(GSF_OFS_GEN, 16'h1080);
		rc(GSF_OFS_MASK, 16'hffff);
		rc(GSF_OFS_LIMIT, 16'h0000);
		rc(GSF_OFS_AIN0, 16'h0000);
		rc(8'h22, 16'h0000);
		@(posedge mclk) trim_done <= 1'b1;
		@(posedge mclk) trim_done <= 1'b0;
		rc(GSF_OFS_GEN, 16'h0080);
		for (int i = 0; i < 7; i++)
		begin
			@(posedge mclk) ev <= gsf_event_type'(7'h01 << i);
			@(posedge mclk) ev <= '0;
			@(posedge mclk);
			chk({15'h0000, summary}, 16'h0000);
			rc(GSF_OFS_GEN, 16'h0080 | (16'h0001 << pos[i]));
			rc(GSF_OFS_GEN, 16'h0080);
		end
		// Event lands on the very edge that takes the read
		fork
			rc(GSF_OFS_GEN, 16'h0080);
			begin
				@(posedge mclk) ev <= gsf_event_type'(7'h11);
				@(posedge mclk) ev <= '0;
			end
		join
		rc(GSF_OFS_GEN, 16'h00c1);
		rc(GSF_OFS_GEN, 16'h0080);
		@(posedge mclk) {run_en, converting, supply_hi} <= 3'h7;
		repeat (4) @(posedge mclk);
		rc(GSF_OFS_GEN, 16'h08b0);
		@(posedge mclk) {run_en, converting, supply_hi} <= 3'h0;
		repeat (4) @(posedge mclk);
		rc(GSF_OFS_GEN, 16'h0080);
		@(posedge mclk) alarm_mask <= 16'h0000;
		alarm_word <= 16'h0001;
		rc(GSF_OFS_GEN, 16'h8080);
		@(posedge mclk) alarm_mask <= 16'h0001;
		rc(GSF_OFS_GEN, 16'h0080);
		host.wr(GSF_OFS_MASK, 16'h0000);
		rc(GSF_OFS_MASK, 16'hf930);
		host.wr(GSF_OFS_MASK, 16'hffbf);
		host.wr(GSF_OFS_LIMIT, 16'h0000);
		rc(GSF_OFS_MASK, 16'hffbf);
		@(posedge mclk) ev.conv_done <= 1'b1;
		@(posedge mclk) ev <= '0;
		@(posedge mclk);
		chk({15'h0000, summary}, 16'h0001);
		rc(GSF_OFS_GEN, 16'h00c0);
		chk({15'h0000, summary}, 16'h0000);
		host.wr(GSF_OFS_MASK, 16'hff7f);
		@(posedge mclk) slew_en <= 1'b1;
		target <= 16'h0010;
		rc(GSF_OFS_GEN, 16'h0000);
		@(posedge mclk) applied <= 16'h0010;
		for (n = 0; n < 10 && slew_evt !== 1'b1; n++)
			@(posedge mclk);
		chk({15'h0000, slew_evt}, 16'h0001);
		@(posedge mclk) slew_en <= 1'b0;
		host.wr(GSF_OFS_MASK, 16'hffff);
		@(posedge mclk) target <= 16'h0020;
		rc(GSF_OFS_GEN, 16'h0000);
		@(posedge mclk) applied <= 16'h0020;
		rc(GSF_OFS_GEN, 16'h0080);
		@(posedge mclk) limit <= gsf_limit_type'(8'h81);
		ain0 <= 12'habc;
		ain0_vld <= 1'b1;
		@(posedge mclk) ain0_vld <= 1'b0;
		ain0 <= 12'h543;
		rc(GSF_OFS_LIMIT, 16'h0102);
		rc(GSF_OFS_AIN0, 16'h0abc);
		@(posedge mclk) limit <= gsf_limit_type'(8'h7e);
		rc(GSF_OFS_LIMIT, 16'h00fc);
		// Frozen clock enable must ignore an event
		@(posedge mclk) ce <= 1'b0;
		ev <= gsf_event_type'(7'h20);
		@(posedge mclk) ce <= 1'b1;
		ev <= '0;
		rc(GSF_OFS_GEN, 16'h0080);
		@(posedge mclk) arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		rc(GSF_OFS_GEN, 16'h1180);
		rc(GSF_OFS_AIN0, 16'h0000);
		results();
	end
endmodule : gsf_status_bank_tb
